// File: core/pfmt_pkg.sv
// Summary of operation
// - reader charges field 15 to 50 ms first; reader here charges for chargeCyc cycles, with no minimum
// - device replies by FSK when charge ends
// - low bit 134.7 kHz, high 123.7 kHz
// - every bit lasts sixteen oscillation cycles
// - whole reply ends within 20 ms
// - 128-bit telegram, stop byte and end bits differ by variant, start byte is shared
// - fixed-code: read right after charge, then discharge
// - NRZ data, bit clock is carrier over sixteen
// - writable enters write mode on full keying
// - gap length codes write bit low or high
// - write bits shift in arrival order
// - carrier-on programming stores all 80 bits together
// - after programming, reply echoes captured data
// - telegram carries 16-bit CRC-CCITT check value
// - reply always starts at telegram bit zero
// - reader may shorten charge, cycle down to 35 ms; reader here enforces no cycle minimum
// - store holds 64 id bits, 16-bit check word
package pfmt_pkg;
  localparam int TELE_BITS = 128;
  localparam int STORE_BITS = 80;
  localparam int ID_BITS = 64;
  localparam int CHK_BITS = 16;
  localparam int CYC_PER_BIT = 16;
  // clock cycles per half period of each carrier (100 MHz clock)
  localparam int CLK_MHZ = 100;
  localparam int CHG_HALF = 372;   // 134.4 kHz
  localparam int LOW_HALF = 371;   // 134.7 kHz
  localparam int HIGH_HALF = 404;  // 123.7 kHz
  localparam int CHG_MIN_MS = 15;
  localparam int CHG_MIN_CYC = CHG_MIN_MS * 1000 * CLK_MHZ;
  localparam int REPLY_MAX_MS = 20;
  localparam int REPLY_MAX_CYC = REPLY_MAX_MS * 1000 * CLK_MHZ;
  // field layout: start byte, 80 store bits, crc, stop byte, end bits
  localparam logic [7:0] START_FIX = 8'h7e;
  localparam logic [7:0] START_RW = 8'h7e;
  localparam logic [7:0] STOP_FIX = 8'h00;
  localparam logic [7:0] STOP_RW = 8'h0f;
  localparam logic [15:0] END_FIX = 16'h0000;
  localparam logic [15:0] END_RW = 16'hffff;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // gap lengths in clock cycles
  localparam int GAP_HIGH_MIN = 8;
  localparam int GAP_END = 64;

  typedef enum logic [2:0] {
    PFMT_IDLE = 3'b000,
    PFMT_CHARGE = 3'b001,
    PFMT_WAIT = 3'b010,
    PFMT_WRITE = 3'b011,
    PFMT_PROG = 3'b100,
    PFMT_REPLY = 3'b101
  } pfmt_state_t;

  function automatic logic [15:0] pfmtCrcStep(input logic [15:0] c,
                                              input logic b);
    pfmtCrcStep = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction
endpackage

// File: core/pfmt_link_if.sv
`timescale 1ns/1ps
// field link: carrier from the reader and FSK oscillation back
interface pfmt_link_if;
  logic fieldOn;     // reader carrier level (toggles while on)
  logic fieldActive; // reader transmitter keyed on
  logic replyOsc;    // transponder oscillation
  logic replyActive;
  modport reader (output fieldOn, output fieldActive,
                  input replyOsc, input replyActive);
  modport tag (input fieldOn, input fieldActive,
               output replyOsc, output replyActive);
endinterface

// File: core/pfmt_fsk_tx.sv
`timescale 1ns/1ps
// sends one telegram; each bit is sixteen oscillation cycles
module pfmt_fsk_tx
  import pfmt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic start,
  input wire logic [pfmt_pkg::TELE_BITS-1:0] frame,
  output logic busy,
  // oscillator
  output logic osc
);
  typedef struct packed {
    logic run;
    logic [TELE_BITS-1:0] sh;
    logic [6:0] bitCnt;
    logic [4:0] halfCnt;
    logic [8:0] tick;
    logic osc;
  } pfmt_tx_t;
  pfmt_tx_t r, next_r;
  logic [8:0] halfLen;

  always_comb begin
    next_r = r;
    // NRZ: level of the current bit picks the frequency
    halfLen = r.sh[TELE_BITS-1] ? 9'(HIGH_HALF - 1) : 9'(LOW_HALF - 1);
    if (!r.run) begin
      if (start) begin
        // always from bit zero of the telegram
        next_r.run = 1'b1;
        next_r.sh = frame;
        next_r.bitCnt = 7'h00;
        next_r.halfCnt = 5'h00;
        next_r.tick = 9'h000;
      end
    end else if (r.tick == halfLen) begin
      next_r.tick = 9'h000;
      next_r.osc = ~r.osc;
      next_r.halfCnt = r.halfCnt + 5'h01;
      if (r.halfCnt == 5'(2 * CYC_PER_BIT - 1)) begin
        next_r.halfCnt = 5'h00;
        next_r.sh = {r.sh[TELE_BITS-2:0], 1'b0};
        next_r.bitCnt = r.bitCnt + 7'h01;
        if (r.bitCnt == 7'(TELE_BITS - 1)) begin
          next_r.run = 1'b0;
          next_r.osc = 1'b0;
        end
      end
    end else begin
      next_r.tick = r.tick + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) r <= '0;
    else r <= next_r;
  end

  assign busy = r.run;
  assign osc = r.osc;
endmodule

// File: core/pfmt_tag.sv
`timescale 1ns/1ps
// transponder end: charge, write, program, reply
module pfmt_tag
  import pfmt_pkg::*;
#(
  parameter logic fixed_code_variant = 1'b0,
  // factory content: 64 id bits then block check word (arbitrary)
  parameter logic [STORE_BITS-1:0] FACTORY = 80'h0123456789abcdef_0000
)(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // field link
  pfmt_link_if.tag link,
  // status
  output logic [pfmt_pkg::STORE_BITS-1:0] storeData,
  output logic progDone
);
  import pfmt_pkg::*;

  typedef struct packed {
    pfmt_state_t st;
    logic [1:0] fOnS;
    logic [1:0] actS;
    logic fOnD;
    logic charged;
    logic [7:0] gap;
    logic [STORE_BITS-1:0] shift;
    logic [STORE_BITS-1:0] store;
    logic [6:0] nBits;
    logic progDone;
    logic txStart;
    logic [TELE_BITS-1:0] frame;
  } pfmt_tag_t;
  pfmt_tag_t r, next_r;
  logic txBusy, txOsc, edgeIn;
  logic [15:0] crc;

  function automatic logic [TELE_BITS-1:0] buildFrame(
      input logic [STORE_BITS-1:0] d);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = STORE_BITS - 1; i >= 0; i--) c = pfmtCrcStep(c, d[i]);
    // variant-specific framing
    if (fixed_code_variant)
      buildFrame = {START_FIX, d, c, STOP_FIX, END_FIX};
    else
      buildFrame = {START_RW, d, c, STOP_RW, END_RW};
  endfunction

  assign edgeIn = r.fOnS[1] & ~r.fOnD;

  always_comb begin
    next_r = r;
    crc = 16'h0000;
    next_r.fOnS = {r.fOnS[0], link.fieldOn};
    next_r.actS = {r.actS[0], link.fieldActive};
    next_r.fOnD = r.fOnS[1];
    next_r.txStart = 1'b0;
    case (r.st)
      PFMT_IDLE: if (r.actS[1]) next_r.st = PFMT_CHARGE;
      PFMT_CHARGE: begin
        // charge-burst end seen as transmitter off
        if (!r.actS[1]) begin
          next_r.gap = 8'h00;
          if (fixed_code_variant) begin
            next_r.frame = buildFrame(r.store);
            next_r.txStart = 1'b1;
            next_r.st = PFMT_REPLY;
          end else begin
            next_r.st = PFMT_WAIT;
          end
        end
      end
      PFMT_WAIT: begin
        // writable: field back on means keying, else plain read
        next_r.gap = r.gap + 8'h01;
        if (r.actS[1]) begin
          // the first keyed-off gap ends here: it carries write bit zero
          next_r.st = PFMT_WRITE;
          next_r.shift = {r.shift[STORE_BITS-2:0],
                          r.gap >= 8'(GAP_HIGH_MIN)};
          next_r.nBits = 7'h01;
          next_r.gap = 8'h00;
        end else if (r.gap == 8'(GAP_END)) begin
          next_r.frame = buildFrame(r.store);
          next_r.txStart = 1'b1;
          next_r.st = PFMT_REPLY;
        end
      end
      PFMT_WRITE: begin
        // gap measured in carrier-less clock slots, threshold param
        if (!r.actS[1]) next_r.gap = r.gap + 8'h01;
        else if (r.gap != 8'h00) begin
          next_r.shift = {r.shift[STORE_BITS-2:0],
                          r.gap >= 8'(GAP_HIGH_MIN)};
          next_r.nBits = r.nBits + 7'h01;
          next_r.gap = 8'h00;
          if (r.nBits == 7'(STORE_BITS - 1)) next_r.st = PFMT_PROG;
        end
      end
      PFMT_PROG: begin
        next_r.store = r.shift; // all bits at once
        next_r.progDone = 1'b1;
        if (!r.actS[1]) begin
          next_r.frame = buildFrame(r.shift); // echo
          next_r.txStart = 1'b1;
          next_r.st = PFMT_REPLY;
        end
      end
      PFMT_REPLY: if (!r.txStart && !txBusy) next_r.st = PFMT_IDLE;
      default: next_r.st = PFMT_IDLE;
    endcase
    if (edgeIn) next_r.charged = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
      r.store <= FACTORY;
    end else begin
      r <= next_r;
    end
  end

  pfmt_fsk_tx uTx (
    .clk(clk),
    .srst(srst),
    .start(r.txStart),
    .frame(r.frame),
    .busy(txBusy),
    .osc(txOsc)
  );

  assign link.replyOsc = txOsc;
  assign link.replyActive = txBusy;
  assign storeData = r.store;
  assign progDone = r.progDone;
endmodule

// File: core/pfmt_reader.sv
`timescale 1ns/1ps
// reader end: charges, optionally writes 80 bits, collects reply
module pfmt_reader
  import pfmt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // user side
  input wire logic go,
  input wire logic doWrite,
  input wire logic [pfmt_pkg::STORE_BITS-1:0] wrData,
  input wire logic [31:0] chargeCyc,
  output logic busy,
  output logic [pfmt_pkg::TELE_BITS-1:0] rxFrame,
  output logic rxValid,
  // field link
  pfmt_link_if.reader link
);
  import pfmt_pkg::*;
  typedef struct packed {
    logic [2:0] ph;
    logic [31:0] cnt;
    logic [8:0] half;
    logic carrier;
    logic [STORE_BITS-1:0] sh;
    logic [6:0] n;
    logic [1:0] oscS;
    logic oscD;
    logic [1:0] actS;
    logic [4:0] cyc;
    logic [15:0] per;
    logic [TELE_BITS-1:0] rx;
    logic rxValid;
  } pfmt_rd_t;
  pfmt_rd_t r, next_r;

  always_comb begin
    next_r = r;
    next_r.rxValid = 1'b0;
    next_r.oscS = {r.oscS[0], link.replyOsc};
    next_r.actS = {r.actS[0], link.replyActive};
    next_r.oscD = r.oscS[1];
    next_r.half = r.half + 9'h001;
    if (r.half == 9'(CHG_HALF - 1)) begin
      next_r.half = 9'h000;
      next_r.carrier = ~r.carrier;
    end
    // carrier stands still while keyed off, so each burst starts whole
    if (!link.fieldActive) begin
      next_r.half = 9'h000;
      next_r.carrier = 1'b0;
    end
    next_r.cnt = r.cnt + 32'h1;
    case (r.ph)
      3'h0: if (go) begin
        next_r.ph = 3'h1;
        next_r.cnt = 32'h0;
        next_r.sh = wrData;
        next_r.n = 7'h00;
      end
      // charge for chargeCyc cycles, no minimum enforced, caller may shorten
      3'h1: if (r.cnt >= chargeCyc) begin
        next_r.cnt = 32'h0;
        next_r.ph = doWrite ? 3'h2 : 3'h5;
      end
      // low gap well under the threshold, high gap well over it
      3'h2: if (r.cnt == (r.sh[STORE_BITS-1] ? 32'(GAP_HIGH_MIN + 4)
                                              : 32'(GAP_HIGH_MIN - 4))) begin
        next_r.cnt = 32'h0;
        next_r.ph = 3'h3;
      end
      3'h3: if (r.cnt == 32'h4) begin
        next_r.cnt = 32'h0;
        next_r.sh = {r.sh[STORE_BITS-2:0], 1'b0};
        next_r.n = r.n + 7'h01;
        next_r.ph = (r.n == 7'(STORE_BITS - 1)) ? 3'h4 : 3'h2;
      end
      3'h4: if (r.cnt == 32'h10) begin
        next_r.cnt = 32'h0;
        next_r.ph = 3'h5;
      end
      3'h5: begin
        // classify each bit by oscillation period, NRZ
        if (r.oscS[1] & ~r.oscD) begin
          next_r.cyc = r.cyc + 5'h01;
          next_r.per = 16'h0;
          if (r.cyc == 5'(CYC_PER_BIT - 1)) begin
            next_r.cyc = 5'h00;
            next_r.rx = {r.rx[TELE_BITS-2:0],
                         r.per > 16'(LOW_HALF * 2 + 16)};
          end
        end else begin
          next_r.per = r.per + 16'h1;
        end
        if (r.cnt > 32'(REPLY_MAX_CYC + 64) ||
            (r.cnt > 32'h100 && !r.actS[1])) begin
          next_r.rxValid = 1'b1;
          next_r.ph = 3'h0;
        end
      end
      default: next_r.ph = 3'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) r <= '0;
    else r <= next_r;
  end

  // keyed-off gaps are fully off: 100% modulation
  assign link.fieldActive = (r.ph == 3'h1) || (r.ph == 3'h3) ||
                            (r.ph == 3'h4);
  assign link.fieldOn = r.carrier & link.fieldActive;
  assign busy = (r.ph != 3'h0);
  assign rxFrame = r.rx;
  assign rxValid = r.rxValid;
endmodule

// File: verification/pfmt_link_assertions.sv
`timescale 1ns/1ps
// ----
// field link checker
// ----
module pfmt_link_assertions
  import pfmt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // field link
  input wire logic fieldOn,
  input wire logic fieldActive,
  input wire logic replyOsc,
  input wire logic replyActive
);
  localparam int DUR_MIN = 4096 * LOW_HALF - HIGH_HALF;
  localparam int DUR_MAX = 4096 * HIGH_HALF + HIGH_HALF;
  logic [31:0] oGap, fGap, dur, offCnt;
  logic oArm, fArm, oPrev, fPrev;
  wire oChg = replyOsc != oPrev;
  wire fChg = fieldOn != fPrev;
  // first toggle of a burst has no known interval, so it only arms
  always_ff @(posedge clk) begin
    if (srst) begin
      {oGap, fGap, dur, offCnt} <= '0;
      {oArm, fArm, oPrev, fPrev} <= '0;
    end else begin
      oPrev <= replyOsc;
      fPrev <= fieldOn;
      oGap <= oChg ? 32'h1 : oGap + 32'h1;
      fGap <= fChg ? 32'h1 : fGap + 32'h1;
      oArm <= replyActive && (oArm || oChg);
      fArm <= fieldActive && (fArm || fChg);
      dur <= replyActive ? dur + 32'h1 : 32'h0;
      offCnt <= fieldActive ? 32'h0 : offCnt + 32'h1;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);
  property p_osc_half;
    replyActive && oArm && oChg |->
      oGap == LOW_HALF || oGap == HIGH_HALF;
  endproperty
  property p_fld_half;
    fieldActive && fArm && fChg |-> fGap == CHG_HALF;
  endproperty
  property p_dur;
    $fell(replyActive) |-> dur >= DUR_MIN && dur <= DUR_MAX;
  endproperty
  property p_max;
    replyActive |-> dur < REPLY_MAX_CYC;
  endproperty
  property p_quiet;
    replyActive |-> !fieldActive;
  endproperty
  property p_start;
    $rose(replyActive) |-> offCnt <= GAP_END + 8;
  endproperty
  property p_osc_still;
    !replyActive && !$past(replyActive) && !$past(replyActive, 2)
      |-> $stable(replyOsc);
  endproperty
  property p_fld_still;
    !fieldActive && !$past(fieldActive) && !$past(fieldActive, 2)
      |-> $stable(fieldOn);
  endproperty
  a_osc_half: assert property (p_osc_half)
    else $error("reply half period off");
  a_fld_half: assert property (p_fld_half)
    else $error("carrier half period off");
  a_dur: assert property (p_dur)
    else $error("reply length off");
  a_max: assert property (p_max)
    else $error("reply too long");
  a_quiet: assert property (p_quiet)
    else $error("field on during reply");
  a_start: assert property (p_start)
    else $error("reply late after field off");
  a_osc_still: assert property (p_osc_still)
    else $error("oscillation outside reply");
  a_fld_still: assert property (p_fld_still)
    else $error("carrier toggles while keyed off");
  cover property ($rose(replyActive));
  cover property ($fell(fieldActive) ##1 !fieldActive);
  cover property ($fell(replyActive));
endmodule

// File: verification/pulsed_fm_transponder_protocol_test.sv
`timescale 1ns/1ps
// ----
// stimulus and scoreboard
// ----
module pulsed_fm_transponder_protocol_test;
  import pfmt_pkg::*;
  // factory content, value arbitrary
  localparam logic [79:0] FACT = 80'h5a5a_1234_c3c3_9876_0f0f;
  localparam int LIM = 2000000;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic go = 1'b0;
  logic doWrite = 1'b0;
  logic [STORE_BITS-1:0] wrData = '0;
  logic [31:0] chargeCyc = 32'h7d0;
  logic busy, rxValid, progDone;
  logic [TELE_BITS-1:0] rxFrame;
  logic [STORE_BITS-1:0] storeData, d;
  logic [TELE_BITS-1:0] expQ[$];
  logic [15:0] rnd = 16'h001a;
  int nErrors = 0;
  int checkCount = 0;
  pfmt_link_if link ();
  pfmt_reader u_pfmt_reader (
    .clk(clk), .srst(srst), .go(go), .doWrite(doWrite),
    .wrData(wrData), .chargeCyc(chargeCyc), .busy(busy),
    .rxFrame(rxFrame), .rxValid(rxValid), .link(link)
  );
  pfmt_tag #(.FACTORY(FACT)) u_pfmt_tag (
    .clk(clk), .srst(srst), .link(link),
    .storeData(storeData), .progDone(progDone)
  );
  pfmt_link_assertions u_pfmt_link_assertions (
    .clk(clk), .srst(srst), .fieldOn(link.fieldOn),
    .fieldActive(link.fieldActive), .replyOsc(link.replyOsc),
    .replyActive(link.replyActive)
  );
  initial forever #5 clk = ~clk;
  function automatic logic [15:0] lfsrStep(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [127:0] frameOf(input logic [79:0] v);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 79; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? CRC_POLY : 16'h0000);
    end
    return {START_RW, v, c, STOP_RW, END_RW};
  endfunction
  task automatic check(input string what, input logic [127:0] seen,
                       input logic [127:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task endOfTest;
    $display("checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // short charge keeps the run short; each reply still takes ~1.6M clocks
  task automatic run(input logic wr, input logic [79:0] v);
    int i;
    @(negedge clk);
    doWrite = wr;
    wrData = v;
    chargeCyc = 32'h7d0 + {24'h0, rnd[7:0]};
    go = 1'b1;
    expQ.push_back(frameOf(v));
    @(negedge clk);
    go = 1'b0;
    repeat (4) @(negedge clk);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (i = 0; i < LIM && busy !== 1'b0; i++) begin
      @(negedge clk);
    end
    if (i == LIM) begin
      nErrors++;
      endOfTest();
    end
    repeat (8) @(negedge clk);
    check("busy", busy, 1'b0);
  endtask
  // ----
  // result watcher
  // ----
  always @(negedge clk) begin
    if (rxValid === 1'b1) begin
      check("rxFrame", rxFrame,
            expQ.size() ? expQ.pop_front() : '0);
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    check("storeData", storeData, FACT);
    check("progDone", progDone, 1'b0);
    run(1'b0, FACT);
    $display("read test done");
    for (int k = 0; k < 5; k++) begin
      rnd = lfsrStep(rnd);
      d = {d[63:0], rnd};
    end
    run(1'b1, d);
    check("storeData", storeData, d);
    check("progDone", progDone, 1'b1);
    $display("write test done");
    run(1'b0, d);
    check("pending", expQ.size(), 0);
    $display("reread test done");
    endOfTest();
  end
endmodule
